// File: oaxc_otp_xip.sv
`include "oaxc_defines.svh"
`default_nettype none

// (otp area with lock bit, self-timed programming and execute-in-place control, decoded from synchronised host pins)
module oaxc_otp_xip
  import oaxc_pkg::*;
#(
  parameter int unsigned PROG_TIME_US = `OAXC_PROG_TIME_US,
  parameter int unsigned PROG_CYCLES = PROG_TIME_US * `OAXC_CLK_MHZ,
  parameter logic [4:0] DUMMY_CYCLES = `OAXC_DUMMY_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // host pins
  input wire oaxc_link_t linkIn,
  output logic [3:0] dqOut,
  output logic [3:0] dqOe,
  input wire logic rstPinN,
  input wire logic rstPinEnable,
  // configuration
  input wire oaxc_proto_t proto,
  input wire logic [2:0] nvXipField,
  input wire logic vcfgWrStb,
  input wire logic vcfgWrBit3,
  // strobes from the general command decoder
  input wire logic welSetStb,
  input wire logic welClrStb,
  input wire logic flagClrStb,
  input wire logic progFault,
  // state
  output oaxc_status_t status
);

  // two-flop synchronisers, third flop for edge finding
  oaxc_link_t linkS1_ff, linkS2_ff;
  logic sclkS3_ff, selS3_ff;
  logic rstS1_ff, rstS2_ff;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      linkS1_ff <= '{selN: 1'b1, sclk: 1'b0, dq: 4'h0};
      linkS2_ff <= '{selN: 1'b1, sclk: 1'b0, dq: 4'h0};
      sclkS3_ff <= 1'b0;
      selS3_ff <= 1'b1;
      rstS1_ff <= 1'b1;
      rstS2_ff <= 1'b1;
    end else begin
      linkS1_ff <= linkIn;
      linkS2_ff <= linkS1_ff;
      sclkS3_ff <= linkS2_ff.sclk;
      selS3_ff <= linkS2_ff.selN;
      rstS1_ff <= rstPinN;
      rstS2_ff <= rstS1_ff;
    end
  end

  logic sclkRise, sclkFall, selActive, selRise, selFall;
  assign sclkRise = linkS2_ff.sclk & ~sclkS3_ff;
  assign sclkFall = ~linkS2_ff.sclk & sclkS3_ff;
  assign selActive = ~linkS2_ff.selN;
  assign selRise = linkS2_ff.selN & ~selS3_ff;
  assign selFall = ~linkS2_ff.selN & selS3_ff;

  // lanes per clock for the enabled protocol
  function automatic logic [3:0] laneWidth(input oaxc_proto_t p);
    case (p)
      OAXC_DUAL: laneWidth = 4'h2;
      OAXC_QUAD: laneWidth = 4'h4;
      default: laneWidth = 4'h1;
    endcase
  endfunction

  // append this clock's input lanes to the shift register
  function automatic logic [23:0] shiftIn(input logic [23:0] sh, input logic [3:0] dq,
                                          input oaxc_proto_t p);
    case (p)
      OAXC_DUAL: shiftIn = {sh[21:0], dq[1:0]};
      OAXC_QUAD: shiftIn = {sh[19:0], dq};
      default: shiftIn = {sh[22:0], dq[0]};
    endcase
  endfunction

  typedef enum {
    OAXC_IDLE,
    OAXC_CMD,
    OAXC_ADDR,
    OAXC_DUMMY,
    OAXC_RDATA,
    OAXC_WDATA,
    OAXC_IGNORE
  } oaxc_state_t;

  oaxc_state_t state_ff;
  oaxc_kind_t kind_ff;
  logic [23:0] shift_ff;
  logic [5:0] bitCnt_ff;
  logic [4:0] dumCnt_ff;
  logic [6:0] rdAddr_ff, wrIdx_ff;
  logic gotByte_ff;
  logic [7:0] otpMem_ff [`OAXC_OTP_BYTES];
  logic [7:0] progBuf_ff [`OAXC_OTP_BYTES];
  logic [7:0] outByte_ff;
  logic [3:0] outCnt_ff;
  logic xipActive_ff, vcfgBit3_ff, bootLoad_ff;
  logic wel_ff, wip_ff, protErr_ff, progFail_ff;
  logic [31:0] progCnt_ff;

  logic [3:0] lanes;
  logic [5:0] bitNext;
  logic [23:0] shiftNext;
  logic locked, progStart, progLockHit, progDone, confirmTaken, confirmBit, nvReload;
  logic rdByteDone;
  assign lanes = laneWidth(proto);
  assign bitNext = bitCnt_ff + {2'h0, lanes};
  assign shiftNext = shiftIn(shift_ff, linkS2_ff.dq, proto);
  assign locked = ~otpMem_ff[`OAXC_CTRL_IDX][`OAXC_LOCK_BIT];
  // program only on a clean byte boundary with at least one byte
  assign progStart = selRise & (state_ff == OAXC_WDATA) & gotByte_ff
                     & (bitCnt_ff == 6'h00) & ~locked;
  assign progLockHit = selRise & (state_ff == OAXC_WDATA) & gotByte_ff
                       & (bitCnt_ff == 6'h00) & locked;
  assign progDone = wip_ff & (progCnt_ff == PROG_CYCLES - 1);
  // confirm bit is line 0 alone; upper lines are don't care here
  assign confirmTaken = selActive & sclkRise & (state_ff == OAXC_DUMMY)
                        & (kind_ff == OAXC_K_FAST) & (dumCnt_ff == 5'h00);
  assign confirmBit = linkS2_ff.dq[0];
  // last lane group of a read byte leaves on this falling clock
  assign rdByteDone = selActive & sclkFall & (state_ff == OAXC_RDATA)
                      & ((outCnt_ff + lanes) == `OAXC_BYTE_BITS);
  // reset pin honoured only while deselected
  assign nvReload = bootLoad_ff | (rstPinEnable & ~rstS2_ff & ~selActive);

  // frame decoder: command, address, dummy and write data phases on rising clock, read address step on falling clock
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= OAXC_IDLE;
      kind_ff <= OAXC_K_NONE;
      shift_ff <= 24'h000000;
      bitCnt_ff <= 6'h00;
      dumCnt_ff <= 5'h00;
      rdAddr_ff <= 7'h00;
      wrIdx_ff <= 7'h00;
      gotByte_ff <= 1'b0;
    end else if (!selActive) begin
      state_ff <= OAXC_IDLE;
    end else if (selFall) begin
      // in xip the frame opens straight on the address
      state_ff <= xipActive_ff ? OAXC_ADDR : OAXC_CMD;
      kind_ff <= xipActive_ff ? OAXC_K_FAST : OAXC_K_NONE;
      bitCnt_ff <= 6'h00;
      dumCnt_ff <= 5'h00;
      gotByte_ff <= 1'b0;
    end else if (rdByteDone) begin
      // stick at the control byte rather than wrap
      if (rdAddr_ff != `OAXC_CTRL_IDX) begin
        rdAddr_ff <= rdAddr_ff + 7'h01;
      end
    end else if (sclkRise) begin
      shift_ff <= shiftNext;
      bitCnt_ff <= bitNext;
      case (state_ff)
        OAXC_CMD: begin
          if (bitNext == `OAXC_CMD_BITS) begin
            bitCnt_ff <= 6'h00;
            state_ff <= OAXC_ADDR;
            case (shiftNext[7:0])
              `OAXC_CMD_READ_OTP: kind_ff <= OAXC_K_READ;
              `OAXC_CMD_FAST_READ: kind_ff <= OAXC_K_FAST;
              `OAXC_CMD_PROG_OTP: begin
                kind_ff <= OAXC_K_PROG;
                if (!wel_ff || wip_ff) begin
                  state_ff <= OAXC_IGNORE;
                end
              end
              default: state_ff <= OAXC_IGNORE;
            endcase
          end
        end
        OAXC_ADDR: begin
          if (bitNext == `OAXC_ADDR_BITS) begin
            bitCnt_ff <= 6'h00;
            // read addresses past the control byte clamp to it, write addresses past it go to the discard index, never wrap
            rdAddr_ff <= (shiftNext > 24'h000040) ? `OAXC_CTRL_IDX : shiftNext[6:0];
            wrIdx_ff <= (shiftNext > 24'h000040) ? `OAXC_DISCARD_IDX : shiftNext[6:0];
            state_ff <= (kind_ff == OAXC_K_PROG) ? OAXC_WDATA : OAXC_DUMMY;
          end
        end
        OAXC_DUMMY: begin
          bitCnt_ff <= 6'h00;
          dumCnt_ff <= dumCnt_ff + 5'h01;
          if (dumCnt_ff == DUMMY_CYCLES - 5'h01) begin
            // fast read data comes from the main array, not this block
            state_ff <= (kind_ff == OAXC_K_READ) ? OAXC_RDATA : OAXC_IGNORE;
          end
        end
        OAXC_WDATA: begin
          if (bitNext == {2'h0, `OAXC_BYTE_BITS}) begin
            bitCnt_ff <= 6'h00;
            gotByte_ff <= 1'b1;
            if (wrIdx_ff != `OAXC_DISCARD_IDX) begin
              wrIdx_ff <= wrIdx_ff + 7'h01;
            end
          end
        end
        default: bitCnt_ff <= 6'h00;
      endcase
    end
  end

  // program staging buffer, erased at each program frame, extra bytes dropped
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `OAXC_OTP_BYTES; i++) begin
        progBuf_ff[i] <= `OAXC_ERASED_BYTE;
      end
    end else if (selFall) begin
      for (int i = 0; i < `OAXC_OTP_BYTES; i++) begin
        progBuf_ff[i] <= `OAXC_ERASED_BYTE;
      end
    end else if (selActive && sclkRise && state_ff == OAXC_WDATA
                 && bitNext == {2'h0, `OAXC_BYTE_BITS} && wrIdx_ff != `OAXC_DISCARD_IDX) begin
      progBuf_ff[wrIdx_ff] <= shiftNext[7:0];
    end
  end

  // programming only takes otp cells 1 to 0, so only nrst (which loads all ones) brings the lock bit back
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `OAXC_OTP_BYTES; i++) begin
        otpMem_ff[i] <= `OAXC_ERASED_BYTE;
      end
    end else if (progDone && !progFault) begin
      for (int i = 0; i < `OAXC_OTP_BYTES; i++) begin
        otpMem_ff[i] <= otpMem_ff[i] & progBuf_ff[i];
      end
    end
  end

  // self-timed program counter and write-in-progress
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wip_ff <= 1'b0;
      progCnt_ff <= 32'h00000000;
    end else if (progStart && !wip_ff) begin
      wip_ff <= 1'b1;
      progCnt_ff <= 32'h00000000;
    end else if (progDone) begin
      wip_ff <= 1'b0;
    end else if (wip_ff) begin
      progCnt_ff <= progCnt_ff + 32'h00000001;
    end
  end

  // write enable latch: program completion clears, lock hit leaves it set
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wel_ff <= 1'b0;
    end else if (progDone) begin
      wel_ff <= 1'b0;
    end else if (welSetStb) begin
      wel_ff <= 1'b1;
    end else if (welClrStb && !wip_ff) begin
      wel_ff <= 1'b0;
    end
  end

  // sticky error flags, a setting event wins over a clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      protErr_ff <= 1'b0;
      progFail_ff <= 1'b0;
    end else begin
      if (progLockHit) begin
        protErr_ff <= 1'b1;
      end else if (flagClrStb) begin
        protErr_ff <= 1'b0;
      end
      if (progLockHit || (progDone && progFault)) begin
        progFail_ff <= 1'b1;
      end else if (flagClrStb) begin
        progFail_ff <= 1'b0;
      end
    end
  end

  // xip mode: boot and reset pin reload from the nonvolatile field
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bootLoad_ff <= 1'b1;
      xipActive_ff <= 1'b0;
      vcfgBit3_ff <= 1'b1;
    end else begin
      bootLoad_ff <= 1'b0;
      if (nvReload) begin
        xipActive_ff <= (nvXipField != `OAXC_NV_XIP_OFF);
        vcfgBit3_ff <= 1'b1;
      end else if (confirmTaken && confirmBit) begin
        xipActive_ff <= 1'b0;
        vcfgBit3_ff <= 1'b1;
      end else begin
        if (confirmTaken && (xipActive_ff || !vcfgBit3_ff)) begin
          xipActive_ff <= 1'b1;
        end
        if (vcfgWrStb) begin
          vcfgBit3_ff <= vcfgWrBit3;
        end
      end
    end
  end

  // read data on falling clock, lanes by protocol, address sticks at 40h
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dqOut <= 4'h0;
      dqOe <= 4'h0;
      outByte_ff <= 8'h00;
      outCnt_ff <= 4'h0;
    end else if (!selActive || state_ff != OAXC_RDATA) begin
      dqOe <= 4'h0;
      outCnt_ff <= 4'h0;
    end else if (sclkFall) begin : rdShift
      logic [7:0] cur;
      cur = (outCnt_ff == 4'h0) ? otpMem_ff[rdAddr_ff] : outByte_ff;
      case (proto)
        OAXC_DUAL: begin
          dqOut <= {2'h0, cur[7:6]};
          dqOe <= 4'h3;
        end
        OAXC_QUAD: begin
          dqOut <= cur[7:4];
          dqOe <= 4'hF;
        end
        default: begin
          dqOut <= {2'h0, cur[7], 1'b0};
          dqOe <= 4'h2;
        end
      endcase
      outByte_ff <= cur << lanes;
      if (outCnt_ff + lanes == `OAXC_BYTE_BITS) begin
        outCnt_ff <= 4'h0;
      end else begin
        outCnt_ff <= outCnt_ff + lanes;
      end
    end
  end

  assign status = '{wip: wip_ff, wel: wel_ff, xipActive: xipActive_ff,
                    vcfgXipDisable: vcfgBit3_ff, otpLocked: locked,
                    flagBits: {3'h0, progFail_ff, 2'h0, protErr_ff, 1'b0}};

endmodule
`default_nettype wire

// File: oaxc_defines.svh
`ifndef OAXC_DEFINES_SVH
`define OAXC_DEFINES_SVH

// one-time-programmable area geometry
`define OAXC_OTP_BYTES 65
`define OAXC_CTRL_IDX 7'h40
`define OAXC_DISCARD_IDX 7'h41
`define OAXC_LOCK_BIT 0
`define OAXC_ERASED_BYTE 8'hFF

// frame layout
`define OAXC_CMD_BITS 6'h08
`define OAXC_ADDR_BITS 6'h18
`define OAXC_BYTE_BITS 4'h8

// command codes and dummy lengths (defaults, may be overridden per part)
`define OAXC_CMD_READ_OTP 8'h4B
`define OAXC_CMD_PROG_OTP 8'h42
`define OAXC_CMD_FAST_READ 8'h0B
`define OAXC_DUMMY_CYCLES 5'h08

// nonvolatile xip field value meaning execute-in-place disabled at boot
`define OAXC_NV_XIP_OFF 3'h7

// flag status bit positions
`define OAXC_FSR_PROT_BIT 1
`define OAXC_FSR_FAIL_BIT 4

// timing: system clock rate and default program duration
`define OAXC_CLK_MHZ 20
`define OAXC_PROG_TIME_US 1000

`endif

// File: oaxc_pkg.sv
`default_nettype none
package oaxc_pkg;

  // line protocol currently enabled
  typedef enum logic [1:0] {
    OAXC_EXT,
    OAXC_DUAL,
    OAXC_QUAD
  } oaxc_proto_t;

  // what the current frame is doing
  typedef enum logic [1:0] {
    OAXC_K_NONE,
    OAXC_K_READ,
    OAXC_K_PROG,
    OAXC_K_FAST
  } oaxc_kind_t;

  // pins arriving from the host, asynchronous to clock
  typedef struct packed {
    logic selN;
    logic sclk;
    logic [3:0] dq;
  } oaxc_link_t;

  // device state visible to the surrounding command logic
  typedef struct packed {
    logic wip;
    logic wel;
    logic xipActive;
    logic vcfgXipDisable;
    logic otpLocked;
    logic [7:0] flagBits;
  } oaxc_status_t;

endpackage
`default_nettype wire

// File: oaxc_otp_xip_assertions.sv
`default_nettype none
// port-level checks of the otp and xip block
module oaxc_otp_xip_assertions
  import oaxc_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // pins and state
  input wire oaxc_link_t linkIn,
  input wire logic [3:0] dqOe,
  input wire logic progFault,
  input wire oaxc_status_t status
);
  int unsigned busyCnt_ff;

  // busy length, counted so the program time is pinned to PROG_CYCLES up to PROG_CYCLES + 2
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busyCnt_ff <= 0;
    end else begin
      busyCnt_ff <= status.wip ? busyCnt_ff + 1 : 0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  a_oe_released: assert property (linkIn.selN [*8] |-> dqOe == 4'h0)
    else $error("data lines driven while deselected");
  a_start_desel: assert property ($rose(status.wip) |-> linkIn.selN)
    else $error("program started while selected");
  a_needs_wel: assert property ($rose(status.wip) |-> $past(status.wel))
    else $error("program started without write enable");
  a_not_locked: assert property ($rose(status.wip) |-> !$past(status.otpLocked))
    else $error("program started on a locked area");
  a_busy_length: assert property ($fell(status.wip) |->
    busyCnt_ff >= PROG_CYCLES && busyCnt_ff <= PROG_CYCLES + 2)
    else $error("program time wrong");
  a_wel_cleared: assert property ($fell(status.wip) |-> ##[0:1] !status.wel)
    else $error("write enable kept after program");
  a_fail_flag: assert property ($fell(status.wip) && progFault |->
    ##[0:1] status.flagBits[4])
    else $error("fail flag not set");
  a_lock_sticky: assert property (status.otpLocked |=> status.otpLocked)
    else $error("lock bit returned to one");
  a_prot_flag: assert property ($rose(status.flagBits[1]) |-> status.otpLocked)
    else $error("protection flag without lock");

  // main scenarios reached
  c_prog: cover property ($fell(status.wip));
  c_lock_hit: cover property ($rose(status.flagBits[1]));
  c_xip: cover property ($rose(status.xipActive));
endmodule

bind oaxc_otp_xip oaxc_otp_xip_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .clock(clock), .nrst(nrst), .linkIn(linkIn), .dqOe(dqOe), .progFault(progFault),
  .status(status));
`default_nettype wire

// File: oaxc_host_model.sv
`default_nettype none
// host controller model: select, link clock and serial lines
module oaxc_host_model
  import oaxc_pkg::*;
(
  // pace
  input wire logic clock,
  // link to the device
  output var oaxc_link_t linkIn,
  input wire logic [3:0] dqOut,
  // byte read back
  output var logic rxValid,
  output var logic [7:0] rxByte
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: deselected, clock parked low
  initial begin
    linkIn = '{selN: 1'h1, sclk: 1'h0, dq: 4'h5};
    rxValid = 1'h0;
    rxByte = 8'h00;
  end

  // one 400 ns link clock; data moves with the fall, upper lines never rest
  task automatic tick(input logic d, output logic q);
    linkIn.sclk <= 1'h0;
    linkIn.dq <= {~linkIn.dq[3:1], d}; // don't-care lines toggled
    repeat (4) @(posedge clock);
    linkIn.sclk <= 1'h1;
    repeat (2) @(posedge clock);
    q = dqOut[1]; // late sample, data stands until next fall
    repeat (2) @(posedge clock);
  endtask

  // whole bytes, most significant bit first
  task automatic put(input logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) tick(b[i], q);
  endtask

  task automatic get();
    logic [7:0] r;
    for (int i = 7; i >= 0; i--) tick(1'h0, r[i]);
    rxByte <= r;
    rxValid <= 1'h1;
    @(posedge clock);
    rxValid <= 1'h0;
  endtask

  // three address bytes
  task automatic addr(input logic [23:0] a);
    put(a[23:16]);
    put(a[15:8]);
    put(a[7:0]);
  endtask

  // only the first dummy carries the confirm value
  task automatic dummy(input int n, input logic c);
    logic q;
    tick(c, q);
    repeat (n - 1) tick(~c, q);
  endtask

  // exit without a reset pin: serial input held high for n clocks
  task automatic xipExit(input int n);
    logic q;
    linkIn.selN <= 1'h0;
    @(posedge clock);
    repeat (n) tick(1'h1, q);
    desel();
  endtask

  task automatic sel();
    linkIn.selN <= 1'h0;
    @(posedge clock);
  endtask

  // clock parked low before select rises, released data line inverted
  task automatic desel();
    linkIn.sclk <= 1'h0;
    repeat (4) @(posedge clock);
    linkIn.selN <= 1'h1;
    linkIn.dq <= ~linkIn.dq;
    repeat (8) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// File: tb.sv
`include "oaxc_defines.svh"
`default_nettype none
// self-checking bench for the otp and xip block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import oaxc_pkg::*;
  localparam int unsigned PCYC = 20;
  logic clock, nrst, rstPinN, rstPinEnable, vcfgWrBit3, progFault, rxValid;
  logic [2:0] nvXipField;
  logic [3:0] dqOut, dqOe, stb;
  logic [7:0] rxByte, d0, d1;
  logic [7:0] expQ[$];
  oaxc_proto_t proto;
  oaxc_link_t linkIn;
  oaxc_status_t status;
  int err_count, compares, cyc;
  int seed = 32'hE63E;

  oaxc_otp_xip #(.PROG_CYCLES(PCYC)) u_dut (
    .clock(clock), .nrst(nrst), .linkIn(linkIn), .dqOut(dqOut), .dqOe(dqOe),
    .rstPinN(rstPinN), .rstPinEnable(rstPinEnable), .proto(proto),
    .nvXipField(nvXipField), .vcfgWrStb(stb[2]), .vcfgWrBit3(vcfgWrBit3),
    .welSetStb(stb[0]), .welClrStb(stb[3]), .flagClrStb(stb[1]),
    .progFault(progFault), .status(status));
  oaxc_host_model u_host (.clock(clock), .linkIn(linkIn), .dqOut(dqOut),
    .rxValid(rxValid), .rxByte(rxByte));

  always #25 clock = ~clock;

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_byte(input logic [7:0] e, input logic [7:0] g);
    check("read byte", e, g);
  endtask

  // busy, latch, xip, volatile bit 3, lock
  task automatic stat(input logic [4:0] e);
    check("state", {3'h0, e}, {3'h0, status.wip, status.wel, status.xipActive,
      status.vcfgXipDisable, status.otpLocked});
  endtask

  task automatic pulse(input int k);
    stb[k] <= 1'h1;
    @(posedge clock);
    stb <= 4'h0;
    @(posedge clock);
  endtask

  // program frame; cut ends it after that many bits of the first data byte
  task automatic prog(input logic [6:0] a, input int cut);
    logic q;
    u_host.sel();
    u_host.put(`OAXC_CMD_PROG_OTP);
    u_host.addr({17'h0, a});
    if (cut > 0) begin
      for (int i = 7; i > 7 - cut; i--) u_host.tick(d0[i], q);
    end else begin
      u_host.put(d0);
      u_host.put(d1);
    end
    u_host.desel();
  endtask

  task automatic rd(input logic [6:0] a, input int n);
    u_host.sel();
    u_host.put(`OAXC_CMD_READ_OTP);
    u_host.addr({17'h0, a});
    u_host.dummy(`OAXC_DUMMY_CYCLES, 1'h0);
    repeat (n) u_host.get();
    u_host.desel();
  endtask

  // fast read, or an address-only frame once xip is on
  task automatic fast(input logic cmd, input logic conf);
    u_host.sel();
    if (cmd) u_host.put(`OAXC_CMD_FAST_READ);
    u_host.addr(24'h000100);
    u_host.dummy(`OAXC_DUMMY_CYCLES, conf);
    u_host.desel();
  endtask

  task automatic print_verdict();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // read bytes against the oldest expectation
  always @(posedge clock) begin
    if (rxValid === 1'h1) check_byte(expQ.pop_front(), rxByte);
  end

  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    clock = 1'h0;
    nrst = 1'h0;
    rstPinN = 1'h1;
    rstPinEnable = 1'h0;
    vcfgWrBit3 = 1'h1;
    progFault = 1'h0;
    nvXipField = `OAXC_NV_XIP_OFF;
    stb = 4'h0;
    proto = OAXC_EXT;
    repeat (4) @(posedge clock);
    nrst <= 1'h1;
    repeat (4) @(posedge clock);
    stat(5'h02);
    d0 = $random(seed);
    d1 = $random(seed);
    prog(7'h3E, 0);
    stat(5'h02); // no latch, ignored
    check("flags", 8'h00, status.flagBits);
    pulse(0);
    prog(7'h3E, 0);
    check("busy", 8'h01, status.wip);
    repeat (PCYC + 10) @(posedge clock);
    stat(5'h02);
    expQ = '{d0, d1, 8'hFF, 8'hFF};
    rd(7'h3E, 4);
    pulse(0);
    prog(7'h00, 5);
    stat(5'h0A); // off a byte boundary
    check("flags", 8'h00, status.flagBits);
    progFault <= 1'h1;
    prog(7'h00, 0);
    repeat (PCYC + 10) @(posedge clock);
    stat(5'h02);
    check("flags", 8'h10, status.flagBits);
    progFault <= 1'h0;
    pulse(1);
    d0 = 8'hFE;
    pulse(0);
    prog(7'h40, 0);
    repeat (PCYC + 10) @(posedge clock);
    stat(5'h03);
    expQ = '{d1, 8'hFE, 8'hFE};
    rd(7'h3F, 3);
    pulse(0);
    prog(7'h00, 0);
    stat(5'h0B); // refused, latch kept
    check("flags", 8'h12, status.flagBits);
    pulse(1);
    pulse(3);
    vcfgWrBit3 <= 1'h0;
    pulse(2);
    fast(1'h1, 1'h0);
    stat(5'h05);
    fast(1'h0, 1'h1);
    stat(5'h03);
    pulse(2);
    fast(1'h1, 1'h0);
    stat(5'h05);
    u_host.xipExit(25);
    check("xip", 8'h00, status.xipActive);
    pulse(2);
    fast(1'h1, 1'h0);
    rstPinEnable <= 1'h1;
    rstPinN <= 1'h0;
    repeat (4) @(posedge clock);
    rstPinN <= 1'h1;
    repeat (8) @(posedge clock);
    check("xip", 8'h00, status.xipActive);
    nvXipField <= 3'h0;
    nrst <= 1'h0;
    repeat (4) @(posedge clock);
    nrst <= 1'h1;
    repeat (4) @(posedge clock);
    check("xip", 8'h01, status.xipActive);
    print_verdict();
  end
endmodule
`default_nettype wire
